// *** hdl/port_protect.sv ***
// Port power protection controller with APB register slave
// Assumes APB master on the same clock; analog comparators give synchronous flags
//
// Summary of operation
// - Limit above ceiling trips switch on overcurrent
// - Over regulation temperature: open, step down, timer
// - Timer expiry closes switch, repeats down to minimum
// - CC at minimum forces trip, ceiling 100 mA
// - Cooling after forced trip waits timer, restores
// - Cooling without forced trip restores at once
// - Trip at minimum holds switch closed, minimum
// - Shutdown temperature turns off port switches
// - Discharge on enable off, undervoltage, removal
// - Discharge on sleep, error recovery, command
// - Discharge when supply moves bypass to switch
// - Bus not low after interval flags error
// - Ration charge accumulates only while active
// - Behaviour change never touches accumulated charge
// - Behaviour change after threshold acts at once
// - Behaviour 00 alerts only, 11 does nothing
// - Behaviour 01 alerts and keeps switch open
// - Behaviour 10 opens switch, sleeps, stops monitoring
// - Error state drives alert output low
`timescale 1ns/1ps
module port_protect
    import protect_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host control and monitor inputs
    input wire logic port_power_enable,
    input wire logic above_reg_temp,
    input wire logic below_reg_hyst,
    input wire logic above_shutdown_temp,
    input wire logic below_shutdown_hyst,
    input wire logic bus_over_limit,
    input wire logic vs_uvlo,
    input wire logic removal_event,
    input wire logic bus_below_test,
    input wire logic charge_tick,
    // Switch controls and status
    output logic [1:0] port_switch_on,
    output logic bypass_on,
    output logic discharge_on,
    output logic [2:0] current_limit_setting,
    output logic trip_mode,
    output logic [11:0] profile_current_ceiling,
    output logic alert_n
);
    import protect_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        power_state_t pst;
        logic en_q;
        logic uvlo_q;
        logic shutdown;
        logic [2:0] lim_prog;
        logic attach_en;
        beh_t beh;
        logic ration_en;
        logic disch_cmd;
        logic recover;
        logic [15:0] thresh;
        logic [15:0] accum;
        logic dfail;
        logic [1:0] sw;
        logic byp;
        logic dis;
        logic [2:0] lim_out;
        logic trip;
        logic [11:0] ceil;
        logic alert_n;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } top_t;

    top_t s;
    top_t next_s;
    protect_if link ();

    thermal_step u_thermal (
        .clock(clock),
        .srst(srst),
        .t(link.thermal)
    );

    bus_discharge u_discharge (
        .clock(clock),
        .srst(srst),
        .d(link.discharge)
    );

    // ********************************************************************
    // Derived conditions
    // ********************************************************************
    logic reached;
    logic monitor;
    logic ration_alert;
    logic ration_block;
    logic ration_sleep;
    logic trip_now;
    logic wr_access;
    logic rd_access;
    logic mapped;
    logic dis_trigger;

    // Ratio state is looked up from the live behaviour so a change acts at once
    assign reached = s.ration_en && (s.accum >= s.thresh);
    assign ration_alert = reached && (s.beh == BEH_REPORT || s.beh == BEH_DISCONNECT);
    assign ration_block = reached && (s.beh == BEH_DISCONNECT || s.beh == BEH_SLEEP);
    assign ration_sleep = reached && (s.beh == BEH_SLEEP);
    assign monitor = !ration_sleep;
    assign trip_now = !link.cc_configured || link.forced_trip;

    assign link.programmed_limit = s.lim_prog;
    assign link.cc_configured = (s.lim_prog <= CEIL_INDEX);
    assign link.above_reg = above_reg_temp;
    assign link.below_reg_hyst = below_reg_hyst;
    assign link.bus_below_test = bus_below_test;
    assign link.start = dis_trigger;

    assign wr_access = psel && penable && pwrite && s.ready;
    assign rd_access = psel && penable && !pwrite && !s.ready;
    assign mapped = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR)
        || (paddr == THRESH_ADDR) || (paddr == ACCUM_ADDR);

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        next_s = s;
        dis_trigger = 1'b0;
        next_s.en_q = port_power_enable;
        next_s.uvlo_q = vs_uvlo;
        next_s.disch_cmd = 1'b0;
        next_s.recover = 1'b0;

        // Thermal shutdown latch with hysteresis
        if (above_shutdown_temp) begin
            next_s.shutdown = 1'b1;
        end else if (below_shutdown_hyst) begin
            next_s.shutdown = 1'b0;
        end

        // Power state
        if (s.pst == PS_ERROR) begin
            if (s.recover) begin
                next_s.pst = port_power_enable ? PS_ACTIVE : PS_SLEEP;
                dis_trigger = 1'b1;
            end
        end else if (ration_sleep) begin
            next_s.pst = PS_SLEEP;
        end else if ((s.pst == PS_ACTIVE && s.sw != 2'b00 && trip_now && bus_over_limit)
            || link.fail) begin
            next_s.pst = PS_ERROR;
        end else if (port_power_enable) begin
            next_s.pst = PS_ACTIVE;
        end else begin
            next_s.pst = s.attach_en ? PS_DETECT : PS_SLEEP;
        end

        // Discharge triggers
        if (s.en_q && !port_power_enable && !ration_sleep) begin
            dis_trigger = 1'b1;
        end
        if (monitor && ((vs_uvlo && !s.uvlo_q) || (removal_event && s.attach_en))) begin
            dis_trigger = 1'b1;
        end
        if (s.pst != PS_SLEEP && next_s.pst == PS_SLEEP) begin
            dis_trigger = 1'b1;
        end
        if (s.disch_cmd && s.pst == PS_ACTIVE) begin
            dis_trigger = 1'b1;
        end
        if (s.attach_en && ((s.pst == PS_DETECT && next_s.pst == PS_ACTIVE)
            || (s.pst == PS_ACTIVE && next_s.pst == PS_DETECT))) begin
            dis_trigger = 1'b1;
        end

        // Rationed charge grows only while active, and is never cleared on attach
        if (s.ration_en && s.pst == PS_ACTIVE && !reached && charge_tick) begin
            next_s.accum = s.accum + 16'h0001;
        end

        // Discharge failure flag: hardware set wins over software clear
        if (wr_access && paddr == STATUS_ADDR && pwdata[STAT_DFAIL_BIT]) begin
            next_s.dfail = 1'b0;
        end
        if (link.fail) begin
            next_s.dfail = 1'b1;
        end

        // APB: one wait state, then write takes effect with pready high
        next_s.ready = psel && penable && !s.ready;
        next_s.err = psel && penable && !s.ready && !mapped;
        if (wr_access && paddr == CTRL_ADDR) begin
            next_s.lim_prog = pwdata[2:0];
            next_s.attach_en = pwdata[CTRL_ATTACH_BIT];
            next_s.beh = beh_t'(pwdata[CTRL_BEH_LSB +: 2]);
            next_s.ration_en = pwdata[CTRL_RATION_BIT];
            next_s.disch_cmd = pwdata[CTRL_DISCH_BIT];
            next_s.recover = pwdata[CTRL_RECOVER_BIT];
        end
        if (wr_access && paddr == THRESH_ADDR) begin
            next_s.thresh = pwdata[15:0];
        end
        if (rd_access) begin
            unique case (paddr)
                CTRL_ADDR: next_s.rdata = {25'h0, s.ration_en, s.beh, s.attach_en, s.lim_prog};
                STATUS_ADDR: next_s.rdata = {21'h0, link.active, reached, s.dfail,
                    s.shutdown, link.forced_trip, trip_now, link.limit_now, s.pst};
                THRESH_ADDR: next_s.rdata = {16'h0, s.thresh};
                ACCUM_ADDR: next_s.rdata = {16'h0, s.accum};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        // Switch outputs: every off condition wins over an enable
        // A trigger keeps the switch open so it never closes into a starting discharge
        next_s.sw = {2{next_s.pst == PS_ACTIVE && !link.open_req && !ration_block
            && !link.active && !dis_trigger && !(vs_uvlo && monitor)}};
        if (next_s.shutdown) begin
            next_s.sw = 2'b00;
        end
        next_s.byp = next_s.pst == PS_DETECT && s.attach_en && !next_s.shutdown
            && !ration_block && !link.active && !dis_trigger;
        next_s.dis = link.active;
        next_s.lim_out = link.limit_now;
        next_s.trip = trip_now;
        next_s.ceil = link.forced_trip ? CEIL_FORCED_MA : CEIL_NORMAL_MA;
        next_s.alert_n = !(next_s.pst == PS_ERROR || ration_alert);
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '{PS_SLEEP, 1'b0, 1'b0, 1'b0, LIMIT_RESET, 1'b0, BEH_DISCONNECT, 1'b0,
                   1'b0, 1'b0, THRESH_RESET, 16'h0000, 1'b0, 2'b00, 1'b0, 1'b0,
                   LIMIT_RESET, 1'b0, CEIL_NORMAL_MA, 1'b1, 32'h0000_0000, 1'b0, 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = s.ready;
    assign pslverr = s.err;
    assign port_switch_on = s.sw;
    assign bypass_on = s.byp;
    assign discharge_on = s.dis;
    assign current_limit_setting = s.lim_out;
    assign trip_mode = s.trip;
    assign profile_current_ceiling = s.ceil;
    assign alert_n = s.alert_n;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence over_in_trip;
        s.pst == PS_ACTIVE && s.sw != 2'b00 && trip_now && bus_over_limit && !ration_sleep;
    endsequence
    sequence switch_opened;
        s.pst == PS_ERROR ##0 s.sw == 2'b00 ##0 !s.alert_n;
    endsequence

    a_trip_open: assert property (over_in_trip |=> switch_opened)
        else $error("overcurrent in trip mode did not open switch");
    a_shutdown_off: assert property (above_shutdown_temp |=> s.sw == 2'b00 && s.shutdown)
        else $error("switches on above shutdown temperature");
    a_enable_disch: assert property (s.en_q && !port_power_enable && !ration_sleep
        |=> ##1 link.active)
        else $error("enable edge did not discharge");
    a_recover_disch: assert property (s.pst == PS_ERROR && s.recover |=> ##1 link.active)
        else $error("error recovery did not discharge");
    a_cmd_disch: assert property (s.disch_cmd && s.pst == PS_ACTIVE |=> ##1 link.active)
        else $error("discharge command did not discharge");
    a_error_alert: assert property (s.pst == PS_ERROR |-> !s.alert_n)
        else $error("error state without alert");
    a_ceil_forced: assert property (link.forced_trip |=> s.ceil == CEIL_FORCED_MA)
        else $error("forced trip ceiling not lowered");
    a_fail_flag: assert property (link.fail |=> s.dfail && s.pst == PS_ERROR)
        else $error("discharge failure not flagged");
    a_accum_idle: assert property (s.pst != PS_ACTIVE |=> s.accum == $past(s.accum))
        else $error("charge accumulated outside active");
    a_ignore_quiet: assert property (reached && s.beh == BEH_IGNORE && s.pst != PS_ERROR
        && next_s.pst != PS_ERROR |=> s.alert_n)
        else $error("ignore behaviour raised alert");
    a_ration_open: assert property (reached && s.beh == BEH_DISCONNECT |=> s.sw == 2'b00
        && !s.byp && !s.alert_n)
        else $error("disconnect behaviour left switch closed");
    a_ration_sleep: assert property (reached && s.beh == BEH_SLEEP && s.pst != PS_ERROR
        |=> s.pst == PS_SLEEP && s.sw == 2'b00)
        else $error("sleep behaviour not taken");
endmodule : port_protect

// *** hdl/protect_pkg.sv ***
// Package for the port power protection block: offsets, fields, reset values, timing
// Assumes a 40 MHz clock; temperature and bus levels arrive as comparator flags
package protect_pkg;

    // ********************************************************************
    // Clock and timing
    // ********************************************************************
    localparam int CLOCK_KHZ = 40000;
    localparam int RETRY_US = 100;
    localparam int RETRY_CYCLES = (RETRY_US * CLOCK_KHZ) / 1000;
    localparam int RESTORE_US = 100;
    localparam int RESTORE_CYCLES = (RESTORE_US * CLOCK_KHZ) / 1000;
    localparam int DISCHARGE_US = 100;
    localparam int DISCHARGE_CYCLES = (DISCHARGE_US * CLOCK_KHZ) / 1000;

    // ********************************************************************
    // Current limit steps and profile ceiling
    // ********************************************************************
    localparam logic [2:0] LIMIT_MIN = 3'h0;
    localparam logic [2:0] CEIL_INDEX = 3'h4;
    localparam logic [11:0] CEIL_NORMAL_MA = 12'h640;
    localparam logic [11:0] CEIL_FORCED_MA = 12'h064;

    // ********************************************************************
    // Register map and fields
    // ********************************************************************
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] THRESH_ADDR = 8'h08;
    localparam logic [7:0] ACCUM_ADDR = 8'h0C;
    localparam int CTRL_ATTACH_BIT = 3;
    localparam int CTRL_BEH_LSB = 4;
    localparam int CTRL_RATION_BIT = 6;
    localparam int CTRL_DISCH_BIT = 8;
    localparam int CTRL_RECOVER_BIT = 9;
    localparam int STAT_DFAIL_BIT = 8;
    localparam logic [2:0] LIMIT_RESET = 3'h7;
    localparam logic [15:0] THRESH_RESET = 16'hFFFF;

    // Rationing behaviour codes
    typedef enum logic [1:0] {
        BEH_REPORT = 2'b00,
        BEH_DISCONNECT = 2'b01,
        BEH_SLEEP = 2'b10,
        BEH_IGNORE = 2'b11
    } beh_t;

    typedef enum logic [1:0] {
        PS_SLEEP = 2'b00,
        PS_DETECT = 2'b01,
        PS_ACTIVE = 2'b10,
        PS_ERROR = 2'b11
    } power_state_t;

    // One step down the limit table, holding at the minimum
    function automatic logic [2:0] step_down(input logic [2:0] idx);
        step_down = (idx == LIMIT_MIN) ? LIMIT_MIN : idx - 3'h1;
    endfunction : step_down

endpackage : protect_pkg

// *** hdl/protect_if.sv ***
// Links the main controller with its thermal and discharge units
// Assumes all three share one clock
`timescale 1ns/1ps
interface protect_if;
    logic [2:0] programmed_limit;
    logic cc_configured;
    logic above_reg;
    logic below_reg_hyst;
    logic [2:0] limit_now;
    logic open_req;
    logic forced_trip;
    logic start;
    logic bus_below_test;
    logic active;
    logic fail;

    modport main (output programmed_limit, cc_configured, above_reg, below_reg_hyst,
                  start, bus_below_test, input limit_now, open_req, forced_trip, active, fail);
    modport thermal (input programmed_limit, cc_configured, above_reg, below_reg_hyst,
                     output limit_now, open_req, forced_trip);
    modport discharge (input start, bus_below_test, output active, fail);
endinterface : protect_if

// *** hdl/thermal_step.sv ***
// Dynamic thermal management: step-down, retry timer, forced trip and restore
// Assumes comparator flags are synchronous and the interface is driven by the controller
`timescale 1ns/1ps
module thermal_step
    import protect_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Controller link
    protect_if.thermal t
);
    import protect_pkg::*;

    typedef enum logic [1:0] {
        TH_IDLE = 2'b00,
        TH_RETRY = 2'b01,
        TH_REG = 2'b10,
        TH_RESTORE = 2'b11
    } th_state_t;

    typedef struct packed {
        th_state_t st;
        logic [2:0] idx;
        logic forced;
        logic open;
        logic [15:0] cnt;
    } th_t;

    th_t s;
    th_t next_s;

    // Step sequencing
    always_comb begin
        next_s = s;
        unique case (s.st)
            TH_IDLE: begin
                next_s.idx = t.programmed_limit;
                next_s.forced = 1'b0;
                if (t.above_reg) begin
                    next_s.idx = step_down(t.programmed_limit);
                    next_s.open = 1'b1;
                    next_s.cnt = 16'(RETRY_CYCLES - 1);
                    next_s.st = TH_RETRY;
                end
            end
            TH_RETRY: begin
                if (s.cnt == 16'h0000) begin
                    next_s.open = 1'b0;
                    next_s.st = TH_REG;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
            TH_REG: begin
                if (t.below_reg_hyst) begin
                    if (s.forced) begin
                        next_s.cnt = 16'(RESTORE_CYCLES - 1);
                        next_s.st = TH_RESTORE;
                    end else begin
                        next_s.idx = t.programmed_limit;
                        next_s.st = TH_IDLE;
                    end
                end else if (t.above_reg) begin
                    if (s.idx != LIMIT_MIN) begin
                        next_s.idx = step_down(s.idx);
                        next_s.open = 1'b1;
                        next_s.cnt = 16'(RETRY_CYCLES - 1);
                        next_s.st = TH_RETRY;
                    end else if (!s.forced && t.cc_configured) begin
                        next_s.forced = 1'b1;
                        next_s.idx = step_down(t.programmed_limit);
                        next_s.open = 1'b1;
                        next_s.cnt = 16'(RETRY_CYCLES - 1);
                        next_s.st = TH_RETRY;
                    end
                    // Trip mode at minimum: switch stays closed, limit held
                end
            end
            TH_RESTORE: begin
                // Heating again during the wait keeps the forced trip mode
                if (t.above_reg) begin
                    next_s.st = TH_REG;
                end else if (s.cnt == 16'h0000) begin
                    next_s.forced = 1'b0;
                    next_s.idx = t.programmed_limit;
                    next_s.st = TH_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 16'h0001;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '{TH_IDLE, LIMIT_RESET, 1'b0, 1'b0, 16'h0000};
        end else begin
            s <= next_s;
        end
    end

    assign t.limit_now = s.idx;
    assign t.open_req = s.open;
    assign t.forced_trip = s.forced;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_heat_step: assert property (s.st == TH_REG && t.above_reg && !t.below_reg_hyst
        && s.idx != LIMIT_MIN |=> s.open && s.idx == $past(s.idx) - 3'h1)
        else $error("limit not stepped down on heat");
    a_first_step: assert property (s.st == TH_IDLE && t.above_reg |=> s.open
        && s.st == TH_RETRY && s.cnt == 16'(RETRY_CYCLES - 1))
        else $error("first regulation step missing");
    a_retry_close: assert property (s.st == TH_RETRY && s.cnt == 16'h0000 |=> !s.open
        && s.st == TH_REG)
        else $error("switch not closed at retry expiry");
    a_force_trip: assert property (s.st == TH_REG && t.above_reg && !t.below_reg_hyst
        && s.idx == LIMIT_MIN && !s.forced && t.cc_configured
        |=> s.forced && s.idx == step_down(t.programmed_limit))
        else $error("forced trip not entered");
    a_trip_hold: assert property (s.st == TH_REG && t.above_reg && !t.below_reg_hyst
        && s.idx == LIMIT_MIN && (s.forced || !t.cc_configured)
        |=> !s.open && s.idx == LIMIT_MIN)
        else $error("minimum limit not held closed");
    a_cool_restore: assert property (s.st == TH_REG && t.below_reg_hyst && !s.forced
        |=> s.st == TH_IDLE && s.idx == $past(t.programmed_limit))
        else $error("restore without timer failed");
endmodule : thermal_step

// *** hdl/bus_discharge.sv ***
// Bus discharge interval timer and end-of-interval level check
// Assumes the bus level comparator is synchronous to the clock
`timescale 1ns/1ps
module bus_discharge
    import protect_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Controller link
    protect_if.discharge d
);
    import protect_pkg::*;

    typedef struct packed {
        logic busy;
        logic fail;
        logic [15:0] cnt;
    } dis_t;

    dis_t s;
    dis_t next_s;

    // A new trigger restarts the interval so the check always sees a full discharge
    always_comb begin
        next_s = s;
        next_s.fail = 1'b0;
        if (d.start) begin
            next_s.busy = 1'b1;
            next_s.cnt = 16'(DISCHARGE_CYCLES - 1);
        end else if (s.busy) begin
            if (s.cnt == 16'h0000) begin
                next_s.busy = 1'b0;
                next_s.fail = !d.bus_below_test;
            end else begin
                next_s.cnt = s.cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (srst) begin
            s <= '{1'b0, 1'b0, 16'h0000};
        end else begin
            s <= next_s;
        end
    end

    assign d.active = s.busy;
    assign d.fail = s.fail;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_check_level: assert property (s.busy && s.cnt == 16'h0000 && !d.start
        |=> d.fail == !$past(d.bus_below_test))
        else $error("discharge check wrong");
endmodule : bus_discharge

// *** sim/load_model.sv ***
// Far-side model: portable load and bus charge seen at the port
// Assumes one clock; outputs follow the switch one cycle later
`timescale 1ns/1ps
module load_model (
    // Clock and scenario controls
    input wire logic clock,
    input wire logic overload,
    input wire logic stuck,
    // Port side
    input wire logic [1:0] port_switch_on,
    output logic bus_over_limit = 1'b0,
    output logic bus_below_test = 1'b1
);
    // Load draws only while powered; a stuck bus never bleeds down
    always_ff @(posedge clock) begin
        bus_over_limit <= overload & port_switch_on[0];
        bus_below_test <= ~stuck & ~port_switch_on[0];
    end
endmodule : load_model

// *** sim/tb_top.sv ***
// Bench for the port protection block: APB tasks and directed sequences
// Assumes the load model answers overcurrent and discharge level
`timescale 1ns/1ps
module tb_top;
    import protect_pkg::*;
    logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, port_power_enable = 0, above_reg_temp = 0, below_reg_hyst = 1;
    logic above_shutdown_temp = 0, below_shutdown_hyst = 1, vs_uvlo = 0, removal_event = 0;
    logic charge_tick = 0, overload = 0, stuck = 0, bus_over_limit, bus_below_test;
    logic bypass_on, discharge_on, trip_mode, alert_n;
    logic [1:0] port_switch_on;
    logic [2:0] current_limit_setting;
    logic [11:0] profile_current_ceiling;
    int n_errors = 0, n_checks = 0, cyc = 0;
    port_protect dut (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_power_enable, .above_reg_temp, .below_reg_hyst,
        .above_shutdown_temp, .below_shutdown_hyst, .bus_over_limit, .vs_uvlo,
        .removal_event, .bus_below_test, .charge_tick, .port_switch_on, .bypass_on,
        .discharge_on, .current_limit_setting, .trip_mode, .profile_current_ceiling, .alert_n);
    load_model load (.clock, .overload, .stuck, .port_switch_on, .bus_over_limit,
        .bus_below_test);
    initial forever #12.5 clock = ~clock;
    // Hang guard: three discharge intervals and five thermal timers, with margin
    always @(posedge clock) if (++cyc == 50000) begin
        n_errors++;
        complete_run();
    end
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock) penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Bounded wait on the switch (s=0) or the discharge flag (s=1)
    task automatic wt(input bit s, input logic e);
        repeat (6000) if ((s ? discharge_on : port_switch_on[0]) !== e) @(posedge clock);
    endtask : wt
    task automatic complete_run;
        if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge clock);
        srst <= 0;
        @(posedge clock);
        chk(current_limit_setting, 32'h7);
        chk(profile_current_ceiling, 32'(CEIL_NORMAL_MA));
        apb(0, CTRL_ADDR, 0);
        chk(rd, 32'h17);
        apb(0, 8'h10, 0);
        chk(err, 1);
        chk(rd, 0);
        port_power_enable <= 1;
        wt(0, 1);
        chk(trip_mode, 1);
        overload <= 1;
        wt(0, 0);
        chk(port_switch_on, 0);
        overload <= 0;
        @(posedge clock);
        chk(alert_n, 0);
        apb(0, STATUS_ADDR, 0);
        chk(rd[1:0], 3);
        apb(1, CTRL_ADDR, 32'h217);
        wt(1, 1);
        chk(discharge_on, 1);
        wt(0, 1);
        apb(0, STATUS_ADDR, 0);
        chk(rd[8], 0);
        above_shutdown_temp <= 1;
        below_shutdown_hyst <= 0;
        wt(0, 0);
        chk(port_switch_on, 0);
        above_shutdown_temp <= 0;
        repeat (20) @(posedge clock);
        chk(port_switch_on, 0);
        below_shutdown_hyst <= 1;
        wt(0, 1);
        chk(port_switch_on, 3);
        apb(1, CTRL_ADDR, 32'h12);
        above_reg_temp <= 1;
        below_reg_hyst <= 0;
        wt(0, 0);
        chk(current_limit_setting, 1);
        wt(0, 1);
        wt(0, 0);
        chk(current_limit_setting, 0);
        wt(0, 1);
        wt(0, 0);
        chk({trip_mode, current_limit_setting}, 4'h9);
        chk(profile_current_ceiling, 32'(CEIL_FORCED_MA));
        wt(0, 1);
        wt(0, 0);
        wt(0, 1);
        repeat (20) @(posedge clock);
        chk({port_switch_on, current_limit_setting}, 5'h18);
        above_reg_temp <= 0;
        below_reg_hyst <= 1;
        repeat (100) @(posedge clock);
        chk(profile_current_ceiling, 32'(CEIL_FORCED_MA));
        repeat (4000) @(posedge clock);
        chk({profile_current_ceiling, current_limit_setting}, {CEIL_NORMAL_MA, 3'h2});
        apb(1, THRESH_ADDR, 2);
        apb(1, CTRL_ADDR, 32'h52);
        charge_tick <= 1;
        repeat (3) @(posedge clock);
        charge_tick <= 0;
        @(posedge clock);
        chk({alert_n, port_switch_on, bypass_on}, 0);
        apb(0, ACCUM_ADDR, 0);
        chk(rd, 2);
        apb(1, CTRL_ADDR, 32'h72);
        @(posedge clock);
        chk({alert_n, port_switch_on}, 3'h7);
        apb(0, ACCUM_ADDR, 0);
        chk(rd, 2);
        apb(1, CTRL_ADDR, 32'h172);
        wt(1, 1);
        chk(discharge_on, 1);
        wt(1, 0);
        stuck <= 1;
        port_power_enable <= 0;
        wt(1, 1);
        chk(discharge_on, 1);
        wt(1, 0);
        repeat (3) @(posedge clock);
        apb(0, STATUS_ADDR, 0);
        chk({rd[8], rd[1:0]}, 3'h7);
        complete_run();
    end
endmodule : tb_top
